// File: hrpc_regs.vh
`ifndef HRPC_REGS_VH
`define HRPC_REGS_VH
// ****************************************
// register byte offsets
// ****************************************
`define HRPC_OFF_CTRL      8'h00
`define HRPC_OFF_ACCF      8'h04
`define HRPC_OFF_ACCB      8'h08
`define HRPC_OFF_DECF      8'h0C
`define HRPC_OFF_DECB      8'h10
`define HRPC_OFF_ALTSCALE  8'h14
`define HRPC_OFF_LOCSCALE  8'h18
`define HRPC_OFF_SMOOTH    8'h1C
`define HRPC_OFF_DELAY     8'h20
`define HRPC_OFF_POSSCALE  8'h24
`define HRPC_OFF_CMDWORD   8'h28
`define HRPC_OFF_BUSREF    8'h2C
`define HRPC_OFF_RAMPRATE  8'h30
`define HRPC_OFF_PRESET    8'h34
`define HRPC_OFF_OPTREF    8'h38
`define HRPC_OFF_LOCREF    8'h3C
`define HRPC_OFF_AIREF     8'h40
`define HRPC_OFF_STATUS    8'h44
`define HRPC_OFF_RAMPOUT   8'h48
`define HRPC_OFF_SPDOUT    8'h4C
`define HRPC_OFF_POSOUT    8'h50
`define HRPC_OFF_PULSES    8'h54
`define HRPC_OFF_TRIM      8'h58
`define HRPC_OFF_TORQUE    8'h5C
`define HRPC_OFF_COMTMO    8'h60
// ****************************************
// control register fields
// ****************************************
`define HRPC_CTRL_STANDALONE 0
`define HRPC_CTRL_LOCAL      1
`define HRPC_CTRL_UNITYRATE  2
`define HRPC_CTRL_ALTSEL     3
`define HRPC_CTRL_MASTER     4
`define HRPC_CTRL_JOYSTICK   5
`define HRPC_CTRL_EDGEMODE   6
`define HRPC_CTRL_ALIGNEDGE  7
`define HRPC_CTRL_LOCDIR     8
`define HRPC_CTRL_BASE10     9
// ****************************************
// command word bits
// ****************************************
`define HRPC_CW_TOGGLE   0
`define HRPC_CW_MAGNET   1
`define HRPC_CW_HISPEED  2
`define HRPC_CW_RUN      3
`define HRPC_CW_FREEZE   4
`define HRPC_CW_INDEP    5
`define HRPC_CW_TORQUE   6
`define HRPC_CW_LOADMEAS 7
`define HRPC_CW_FCLEAR   8
`define HRPC_CW_QSTOP    9
`define HRPC_CW_QSTYPE   10
`define HRPC_CW_SOFTSYNC 11
`define HRPC_CW_PINBLOCK 12
`define HRPC_CW_SYNCRST  13
`define HRPC_CW_USERSET  14
`define HRPC_CW_BUSPERM  15
// ****************************************
// reset values and scaling
// ****************************************
`define HRPC_RST_CTRL      32'h0000_0000
`define HRPC_RST_DURATION  16'h0005
`define HRPC_RST_SCALE1    16'h03E8
`define HRPC_RST_LOCSCALE  16'h07D0
`define HRPC_RST_POSSCALE  16'h0001
`define HRPC_RST_COMTMO    16'h0064
`define HRPC_FULL_SCALE    32'h0000_4E20
`define HRPC_RATE_UNITY    32'h0000_03E8
`define HRPC_DSET_SHIFT    4'h9
`define HRPC_DSET_ALT      4'hA
`define HRPC_DSET_DEF      4'h1
// ****************************************
// timing
// ****************************************
`define HRPC_CLK_HZ        50000000
`define HRPC_TICK_US       1000
`define HRPC_SLOW_MS       32
`define HRPC_FAST_MS       8
`endif

// File: hrpc_top.v
// Function
// - four ramp durations chosen by direction and rising or falling magnitude
// - alternative ramp set is normal durations times one common factor
// - bus control uses received ramp rate unless unity-rate flag set
// - standalone uses configured alt factor when selected or select pin high
// - local mode scales by local factor, default 2.0, fixed 1.0 as master
// - s-curve rounds ramp start with configurable smoothing time, last step clamped to target
// - bus control reference is max of bus target and optimised target
// - standalone uses min of operator and optimised target
// - local mode uses panel reference and panel direction
// - reference to speed controller delayed by configurable time
// - position is pulse count divided by position scale
// - count all edges of A and B by default, none when A and B change in the same cycle, edge mode selectable
// - sync loads preset from soft command or hardware pin
// - pin sync ignored while drive not running
// - sync-done set after sync, cleared by command bit 13
// - command bit 12 blocks pin sync, edge chosen by setting
// - fixed receive block, command word unpacked into 16 booleans
// - datasets refresh each 32 ms, speed torque trim words each 8 ms
// - dataset base 10 shifts every index up by 9
// - bits 5 to 10 independent, torque, load, fault edge, stops
// - bits 11 to 15 sync edge, block, sync reset, user set, permit
// - speed words 20000 is 100 percent, torque 10000
// - echo inverted toggle, trip when no toggle edge within timeout
//
// The placing of the registers and the AXI4-Lite register port were left to the implementer.
`include "hrpc_regs.vh"
`default_nettype none
module hrpc_top #(
  parameter integer TICK_CYCLES = (`HRPC_CLK_HZ / 1000000) * `HRPC_TICK_US
) (
  input  wire        I_CORE_CLK,
  input  wire        I_ARST_N,
  input  wire [7:0]  S_AXI_AWADDR,
  input  wire        S_AXI_AWVALID,
  output wire        S_AXI_AWREADY,
  input  wire [31:0] S_AXI_WDATA,
  input  wire [3:0]  S_AXI_WSTRB,
  input  wire        S_AXI_WVALID,
  output wire        S_AXI_WREADY,
  output reg  [1:0]  S_AXI_BRESP,
  output reg         S_AXI_BVALID,
  input  wire        S_AXI_BREADY,
  input  wire [7:0]  S_AXI_ARADDR,
  input  wire        S_AXI_ARVALID,
  output wire        S_AXI_ARREADY,
  output reg  [31:0] S_AXI_RDATA,
  output reg  [1:0]  S_AXI_RRESP,
  output reg         S_AXI_RVALID,
  input  wire        S_AXI_RREADY,
  input  wire        i_enc_a,
  input  wire        i_enc_b,
  input  wire        i_align_pin,
  input  wire        i_alt_ramp_pin,
  input  wire        i_running,
  output reg  [15:0] o_speed_ref,
  output reg  [31:0] o_scaled_position_out,
  output reg         o_sync_done,
  output reg         o_link_toggle_out,
  output reg         o_comm_fault,
  output reg         o_fault_clear_edge,
  output reg  [15:0] o_cmd_bits
);
  // ****************************************
  // reset release
  // ****************************************
  reg  [1:0]  rst_sync;
  wire        rst_n = rst_sync[1];
  // two stages so release is clean against the clock
  always @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) rst_sync <= 2'b00;
    else rst_sync <= {rst_sync[0], 1'b1};
  end

  // ****************************************
  // registers
  // ****************************************
  reg  [31:0] ctrl;
  reg  [15:0] accel_duration_fwd, accel_duration_back;
  reg  [15:0] decel_duration_fwd, decel_duration_back;
  reg  [15:0] alt_scale, local_scale, curve_smoothing_time, target_release_delay;
  reg  [15:0] pos_scale, com_timeout;
  reg  [15:0] cmd_shadow, bus_velocity_target, ramp_rate_shadow, position_preset_value;
  reg  [15:0] bus_torque_target, bus_velocity_trim;
  reg  [15:0] cmd_word, bus_ref_live, ramp_rate, preset_live, torque_live, trim_live;
  reg  [15:0] optimised_velocity_target, local_ref, analog_ref;
  reg         cmd_pending;

  // ****************************************
  // axi4-lite slave
  // ****************************************
  reg         aw_hold, w_hold;
  reg  [7:0]  aw_addr;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;
  assign S_AXI_AWREADY = !aw_hold && !S_AXI_BVALID;
  assign S_AXI_WREADY  = !w_hold && !S_AXI_BVALID;
  assign S_AXI_ARREADY = !S_AXI_RVALID;
  wire        wr_go = aw_hold && w_hold;

  function [15:0] merge16;
    input [15:0] old;
    input [31:0] d;
    input [3:0]  s;
    begin
      merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    end
  endfunction

  function is_mapped;
    input [7:0] a;
    begin
      is_mapped = (a[1:0] == 2'b00) && (a <= `HRPC_OFF_COMTMO);
    end
  endfunction

  // address and data latched in either order, response after both
  always @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= 2'b00;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_hold <= 1'b1;
        aw_addr <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_hold <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end
      if (wr_go) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= is_mapped(aw_addr) ? 2'b00 : 2'b10;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // register writes; received words land in shadows until the next refresh
  always @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= `HRPC_RST_CTRL;
      accel_duration_fwd <= `HRPC_RST_DURATION;
      accel_duration_back <= `HRPC_RST_DURATION;
      decel_duration_fwd <= `HRPC_RST_DURATION;
      decel_duration_back <= `HRPC_RST_DURATION;
      alt_scale <= `HRPC_RST_SCALE1;
      local_scale <= `HRPC_RST_LOCSCALE;
      curve_smoothing_time <= 16'h0000;
      target_release_delay <= 16'h0000;
      pos_scale <= `HRPC_RST_POSSCALE;
      com_timeout <= `HRPC_RST_COMTMO;
      cmd_shadow <= 16'h0000;
      bus_velocity_target <= 16'h0000;
      ramp_rate_shadow <= `HRPC_RST_SCALE1;
      position_preset_value <= 16'h0000;
      optimised_velocity_target <= 16'h0000;
      local_ref <= 16'h0000;
      analog_ref <= 16'h0000;
      bus_velocity_trim <= 16'h0000;
      bus_torque_target <= 16'h0000;
    end else if (wr_go) begin
      case (aw_addr)
        `HRPC_OFF_CTRL:     ctrl <= {16'h0000, merge16(ctrl[15:0], w_data, w_strb)};
        `HRPC_OFF_ACCF:     accel_duration_fwd <= merge16(accel_duration_fwd, w_data, w_strb);
        `HRPC_OFF_ACCB:     accel_duration_back <= merge16(accel_duration_back, w_data, w_strb);
        `HRPC_OFF_DECF:     decel_duration_fwd <= merge16(decel_duration_fwd, w_data, w_strb);
        `HRPC_OFF_DECB:     decel_duration_back <= merge16(decel_duration_back, w_data, w_strb);
        `HRPC_OFF_ALTSCALE: alt_scale <= merge16(alt_scale, w_data, w_strb);
        `HRPC_OFF_LOCSCALE: local_scale <= merge16(local_scale, w_data, w_strb);
        `HRPC_OFF_SMOOTH:   curve_smoothing_time <= merge16(curve_smoothing_time, w_data, w_strb);
        `HRPC_OFF_DELAY:    target_release_delay <= merge16(target_release_delay, w_data, w_strb);
        `HRPC_OFF_POSSCALE: pos_scale <= merge16(pos_scale, w_data, w_strb);
        `HRPC_OFF_CMDWORD:  cmd_shadow <= merge16(cmd_shadow, w_data, w_strb);
        `HRPC_OFF_BUSREF:   bus_velocity_target <= merge16(bus_velocity_target, w_data, w_strb);
        `HRPC_OFF_RAMPRATE: ramp_rate_shadow <= merge16(ramp_rate_shadow, w_data, w_strb);
        `HRPC_OFF_PRESET:   position_preset_value <= merge16(position_preset_value, w_data, w_strb);
        `HRPC_OFF_OPTREF:   optimised_velocity_target <= merge16(optimised_velocity_target, w_data, w_strb);
        `HRPC_OFF_LOCREF:   local_ref <= merge16(local_ref, w_data, w_strb);
        `HRPC_OFF_AIREF:    analog_ref <= merge16(analog_ref, w_data, w_strb);
        `HRPC_OFF_TRIM:     bus_velocity_trim <= merge16(bus_velocity_trim, w_data, w_strb);
        `HRPC_OFF_TORQUE:   bus_torque_target <= merge16(bus_torque_target, w_data, w_strb);
        `HRPC_OFF_COMTMO:   com_timeout <= merge16(com_timeout, w_data, w_strb);
        default: ;
      endcase
    end
  end

  // ****************************************
  // task tick and dataset refresh
  // ****************************************
  localparam integer SLOW_TICKS = `HRPC_SLOW_MS * 1000 / `HRPC_TICK_US;
  localparam integer FAST_TICKS = `HRPC_FAST_MS * 1000 / `HRPC_TICK_US;
  reg  [31:0] tick_cnt;
  reg  [7:0]  slow_cnt;
  reg         tick;
  wire        fast_upd = tick && ((slow_cnt % FAST_TICKS) == 0);
  wire        slow_upd = tick && (slow_cnt == 8'h00);
  wire [3:0]  dset_base = ctrl[`HRPC_CTRL_BASE10] ? `HRPC_DSET_ALT : `HRPC_DSET_DEF;
  always @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt <= 32'h0000_0000;
      slow_cnt <= 8'h00;
      tick <= 1'b0;
    end else begin
      tick <= (tick_cnt == TICK_CYCLES - 1);
      tick_cnt <= (tick_cnt == TICK_CYCLES - 1) ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
      if (tick) slow_cnt <= (slow_cnt == SLOW_TICKS - 1) ? 8'h00 : slow_cnt + 8'h01;
    end
  end
  // fast words every 8 ms, rest of the block every 32 ms
  always @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      cmd_word <= 16'h0000;
      bus_ref_live <= 16'h0000;
      ramp_rate <= `HRPC_RST_SCALE1;
      preset_live <= 16'h0000;
      torque_live <= 16'h0000;
      trim_live <= 16'h0000;
    end else begin
      if (fast_upd) begin
        bus_ref_live <= bus_velocity_target;
        torque_live <= bus_torque_target;
        trim_live <= bus_velocity_trim;
      end
      if (slow_upd) begin
        cmd_word <= cmd_shadow;
        ramp_rate <= ramp_rate_shadow;
        preset_live <= position_preset_value;
      end
    end
  end
  // unpacked command booleans, one per bit
  always @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) o_cmd_bits <= 16'h0000;
    else o_cmd_bits <= cmd_word;
  end

  // ****************************************
  // reference selection and ramp
  // ****************************************
  wire        standalone = ctrl[`HRPC_CTRL_STANDALONE];
  wire        local_mode = ctrl[`HRPC_CTRL_LOCAL];
  wire signed [15:0] oper_ref = ctrl[`HRPC_CTRL_JOYSTICK] ? bus_ref_live : analog_ref;
  wire signed [15:0] opt_ref = optimised_velocity_target;
  wire signed [15:0] loc_signed = ctrl[`HRPC_CTRL_LOCDIR] ? -$signed(local_ref) : local_ref;
  reg  signed [15:0] sel_ref;
  reg  [15:0] factor;
  always @* begin
    if (local_mode) begin
      sel_ref = loc_signed;
      factor = ctrl[`HRPC_CTRL_MASTER] ? `HRPC_RST_SCALE1 : local_scale;
    end else if (standalone) begin
      sel_ref = (oper_ref < opt_ref) ? oper_ref : opt_ref;
      factor = (ctrl[`HRPC_CTRL_ALTSEL] || i_alt_ramp_pin) ? alt_scale : `HRPC_RST_SCALE1;
    end else begin
      sel_ref = ($signed(bus_ref_live) > opt_ref) ? bus_ref_live : opt_ref;
      factor = ctrl[`HRPC_CTRL_UNITYRATE] ? `HRPC_RST_SCALE1 : ramp_rate;
    end
  end

  reg  signed [15:0] ramp_out;
  reg  signed [15:0] step_now;
  wire        rising = (sel_ref > ramp_out) ? (ramp_out >= 0) : (ramp_out < 0);
  wire        fwd = (ramp_out > 0) || (ramp_out == 0 && sel_ref > 0);
  // pick one of four durations, then scale by common factor
  wire [15:0] base_dur = rising ? (fwd ? accel_duration_fwd : accel_duration_back)
                                : (fwd ? decel_duration_fwd : decel_duration_back);
  wire [31:0] eff_dur = base_dur * factor / `HRPC_RATE_UNITY;
  wire [31:0] full_step = `HRPC_FULL_SCALE / ((eff_dur == 0) ? 32'h1 : eff_dur);
  // s-curve: step grows by full_step/tc plus one unit per tick near start, so small tc means fast ramp
  wire [15:0] smooth_lim = (curve_smoothing_time == 0) ? full_step[15:0] :
                           step_now + full_step[15:0] / curve_smoothing_time + 16'h1;
  wire [15:0] diff = (sel_ref > ramp_out) ? sel_ref - ramp_out : ramp_out - sel_ref;
  wire [15:0] cand = (smooth_lim < full_step[15:0]) ? smooth_lim : full_step[15:0];
  // clamping the step to the remaining distance makes the last step land on target
  wire [15:0] step_use = (cand > diff) ? diff : cand;
  always @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      ramp_out <= 16'h0000;
      step_now <= 16'h0000;
    end else if (tick && !cmd_word[`HRPC_CW_FREEZE]) begin
      step_now <= (diff <= step_now) ? diff : step_use;
      ramp_out <= (sel_ref > ramp_out) ? ramp_out + step_use : ramp_out - step_use;
    end
  end

  // output delay: hold zero until delay elapses after a nonzero request
  reg  [15:0] delay_cnt;
  always @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      delay_cnt <= 16'h0000;
      o_speed_ref <= 16'h0000;
    end else if (tick) begin
      if (ramp_out == 0 && sel_ref == 0) delay_cnt <= 16'h0000;
      else if (delay_cnt < target_release_delay) delay_cnt <= delay_cnt + 16'h0001;
      o_speed_ref <= (delay_cnt >= target_release_delay) ? ramp_out + trim_live : 16'h0000;
    end
  end

  // ****************************************
  // position measurement
  // ****************************************
  reg  [1:0]  enc_q;
  reg         pin_q, cmd_sync_q, fclr_q, tog_q;
  reg  signed [31:0] pulse_cnt;
  wire        a_edge = i_enc_a ^ enc_q[0];
  wire        b_edge = i_enc_b ^ enc_q[1];
  // quadrature direction from edge against other channel
  wire        up = a_edge ? (i_enc_a ^ i_enc_b) : ~(i_enc_a ^ i_enc_b);
  wire        cnt_en = ctrl[`HRPC_CTRL_EDGEMODE] ? (a_edge && i_enc_a) : (a_edge || b_edge);
  wire        pin_edge = ctrl[`HRPC_CTRL_ALIGNEDGE] ? (pin_q && !i_align_pin) : (!pin_q && i_align_pin);
  wire        pin_sync = pin_edge && i_running && !cmd_word[`HRPC_CW_PINBLOCK];
  wire        soft_align_cmd = cmd_word[`HRPC_CW_SOFTSYNC] && !cmd_sync_q;
  wire        do_sync = soft_align_cmd || pin_sync;
  always @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      enc_q <= 2'b00;
      pin_q <= 1'b0;
      cmd_sync_q <= 1'b0;
      pulse_cnt <= 32'h0000_0000;
      o_sync_done <= 1'b0;
      o_scaled_position_out <= 32'h0000_0000;
    end else begin
      enc_q <= {i_enc_b, i_enc_a};
      pin_q <= i_align_pin;
      cmd_sync_q <= cmd_word[`HRPC_CW_SOFTSYNC];
      if (do_sync) pulse_cnt <= $signed(preset_live) * $signed({16'h0000, pos_scale});
      else if (cnt_en && a_edge && b_edge) pulse_cnt <= pulse_cnt;
      else if (cnt_en) pulse_cnt <= up ? pulse_cnt + 1 : pulse_cnt - 1;
      // set wins over the controller's reset bit
      if (do_sync) o_sync_done <= 1'b1;
      else if (cmd_word[`HRPC_CW_SYNCRST]) o_sync_done <= 1'b0;
      o_scaled_position_out <= pulse_cnt / $signed({16'h0000, (pos_scale == 0) ? 16'h1 : pos_scale});
    end
  end

  // ****************************************
  // link supervision and fault clear edge
  // ****************************************
  reg  [31:0] tmo_cnt;
  always @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      tog_q <= 1'b0;
      fclr_q <= 1'b0;
      tmo_cnt <= 32'h0000_0000;
      o_link_toggle_out <= 1'b1;
      o_comm_fault <= 1'b0;
      o_fault_clear_edge <= 1'b0;
    end else begin
      tog_q <= cmd_word[`HRPC_CW_TOGGLE];
      fclr_q <= cmd_word[`HRPC_CW_FCLEAR];
      o_fault_clear_edge <= cmd_word[`HRPC_CW_FCLEAR] && !fclr_q;
      o_link_toggle_out <= ~cmd_word[`HRPC_CW_TOGGLE];
      if (cmd_word[`HRPC_CW_TOGGLE] != tog_q) tmo_cnt <= 32'h0000_0000;
      else if (tick && !o_comm_fault) tmo_cnt <= tmo_cnt + 32'h0000_0001;
      // trip latched until a fault clear edge after a toggle edge has restarted tmo_cnt
      if (tmo_cnt >= {16'h0000, com_timeout}) o_comm_fault <= 1'b1;
      else if (o_fault_clear_edge) o_comm_fault <= 1'b0;
    end
  end

  // ****************************************
  // read path
  // ****************************************
  wire [31:0] status = {24'h00_0000, dset_base,
                        o_comm_fault, o_link_toggle_out, o_sync_done, i_running};
  always @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= 2'b00;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RRESP <= is_mapped(S_AXI_ARADDR) ? 2'b00 : 2'b10;
      case (S_AXI_ARADDR)
        `HRPC_OFF_CTRL:     S_AXI_RDATA <= ctrl;
        `HRPC_OFF_ACCF:     S_AXI_RDATA <= {16'h0000, accel_duration_fwd};
        `HRPC_OFF_ACCB:     S_AXI_RDATA <= {16'h0000, accel_duration_back};
        `HRPC_OFF_DECF:     S_AXI_RDATA <= {16'h0000, decel_duration_fwd};
        `HRPC_OFF_DECB:     S_AXI_RDATA <= {16'h0000, decel_duration_back};
        `HRPC_OFF_ALTSCALE: S_AXI_RDATA <= {16'h0000, alt_scale};
        `HRPC_OFF_LOCSCALE: S_AXI_RDATA <= {16'h0000, local_scale};
        `HRPC_OFF_SMOOTH:   S_AXI_RDATA <= {16'h0000, curve_smoothing_time};
        `HRPC_OFF_DELAY:    S_AXI_RDATA <= {16'h0000, target_release_delay};
        `HRPC_OFF_POSSCALE: S_AXI_RDATA <= {16'h0000, pos_scale};
        `HRPC_OFF_CMDWORD:  S_AXI_RDATA <= {16'h0000, cmd_word};
        `HRPC_OFF_BUSREF:   S_AXI_RDATA <= {16'h0000, bus_ref_live};
        `HRPC_OFF_RAMPRATE: S_AXI_RDATA <= {16'h0000, ramp_rate};
        `HRPC_OFF_PRESET:   S_AXI_RDATA <= {16'h0000, preset_live};
        `HRPC_OFF_OPTREF:   S_AXI_RDATA <= {16'h0000, optimised_velocity_target};
        `HRPC_OFF_LOCREF:   S_AXI_RDATA <= {16'h0000, local_ref};
        `HRPC_OFF_AIREF:    S_AXI_RDATA <= {16'h0000, analog_ref};
        `HRPC_OFF_STATUS:   S_AXI_RDATA <= status;
        `HRPC_OFF_RAMPOUT:  S_AXI_RDATA <= {16'h0000, ramp_out};
        `HRPC_OFF_SPDOUT:   S_AXI_RDATA <= {16'h0000, o_speed_ref};
        `HRPC_OFF_POSOUT:   S_AXI_RDATA <= o_scaled_position_out;
        `HRPC_OFF_PULSES:   S_AXI_RDATA <= pulse_cnt;
        `HRPC_OFF_TRIM:     S_AXI_RDATA <= {16'h0000, trim_live};
        `HRPC_OFF_TORQUE:   S_AXI_RDATA <= {16'h0000, torque_live};
        `HRPC_OFF_COMTMO:   S_AXI_RDATA <= {16'h0000, com_timeout};
        default:            S_AXI_RDATA <= 32'h0000_0000;
      endcase
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: hrpc_enc_model.sv
`default_nettype none
module hrpc_enc_model (
  input  wire logic I_CORE_CLK,
  input  wire logic i_step,
  output var logic  o_a = 1'b0,
  output var logic  o_b = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  // gray walk: one edge per step, four per line
  always @(posedge I_CORE_CLK) if (i_step) {o_a, o_b} <= {o_b, !o_a};
endmodule
`default_nettype wire

// File: hrpc_monitor.sv
`default_nettype none
module hrpc_monitor (
  input wire logic        I_CORE_CLK,
  input wire logic        I_ARST_N,
  input wire logic        i_running,
  input wire logic        o_sync_done,
  input wire logic        o_link_toggle_out,
  input wire logic        o_fault_clear_edge,
  input wire logic [15:0] o_cmd_bits
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_ARST_N);
  // lag of one cycle between word and flags is allowed
  property p_tg; $stable(o_cmd_bits)[*2] |-> o_link_toggle_out != o_cmd_bits[0]; endproperty
  a_tg: assert property (p_tg) else $error("toggle echo");
  property p_fp; o_fault_clear_edge |=> !o_fault_clear_edge; endproperty
  a_fp: assert property (p_fp) else $error("clear pulse long");
  property p_fc; o_fault_clear_edge |-> ##[0:1] o_cmd_bits[8]; endproperty
  a_fc: assert property (p_fc) else $error("clear pulse cause");
  property p_sh; o_sync_done && !o_cmd_bits[13] |=> o_sync_done || o_cmd_bits[13]; endproperty
  a_sh: assert property (p_sh) else $error("sync done lost");
  property p_sc; $fell(o_sync_done) |-> o_cmd_bits[13] || $past(o_cmd_bits[13]); endproperty
  a_sc: assert property (p_sc) else $error("sync done cleared");
  property p_pr; $rose(o_sync_done) && !o_cmd_bits[11] |-> $past(i_running); endproperty
  a_pr: assert property (p_pr) else $error("pin sync idle");
  property p_pb; $rose(o_sync_done) && !o_cmd_bits[11] |-> !o_cmd_bits[12]; endproperty
  a_pb: assert property (p_pb) else $error("pin sync blocked");
  property p_rf; $changed(o_cmd_bits) |=> $stable(o_cmd_bits)[*8]; endproperty
  a_rf: assert property (p_rf) else $error("word refresh");
  c_sy: cover property ($rose(o_sync_done));
  c_fc: cover property (o_fault_clear_edge);
  c_cw: cover property ($changed(o_cmd_bits));
endmodule
bind hrpc_top hrpc_monitor u_mon (.*);
`default_nettype wire

// File: tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic I_CORE_CLK = 0, I_ARST_N = 0, S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0;
  logic S_AXI_ARVALID = 0, S_AXI_RREADY = 0, i_align_pin = 0, i_running = 1, stp = 0;
  logic i_alt_ramp_pin = 0, i_enc_a, i_enc_b, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID;
  logic S_AXI_ARREADY, S_AXI_RVALID, o_sync_done, o_link_toggle_out, o_comm_fault;
  logic o_fault_clear_edge;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
  logic [3:0] S_AXI_WSTRB = 4'hF;
  logic [7:0] S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00;
  logic [15:0] o_speed_ref, o_cmd_bits, w;
  logic [31:0] S_AXI_WDATA = 0, S_AXI_RDATA, o_scaled_position_out, n;
  logic [33:0] r;
  int fails = 0, samples_checked = 0, cyc = 0;
  hrpc_top #(.TICK_CYCLES(10)) dut (.*);
  hrpc_enc_model u_enc (.I_CORE_CLK, .i_step(stp), .o_a(i_enc_a), .o_b(i_enc_b));
  initial forever #10 I_CORE_CLK = ~I_CORE_CLK;
  task conclude;
    if (fails == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task ck(input string s, input logic [33:0] e, input logic [33:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  task wt; repeat (500) @(posedge I_CORE_CLK); endtask
  // waits span one slow refresh, so the word is applied
  task wr(input logic [7:0] a, input logic [31:0] d);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'b111;
    do begin
      @(posedge I_CORE_CLK);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 0;
    end while (S_AXI_BVALID !== 1'b1);
    S_AXI_BREADY <= 0;
    wt;
  endtask
  task rd(input logic [7:0] a);
    S_AXI_ARADDR <= a;
    {S_AXI_ARVALID, S_AXI_RREADY} <= 2'b11;
    do begin
      @(posedge I_CORE_CLK);
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 0;
    end while (S_AXI_RVALID !== 1'b1);
    r = {S_AXI_RRESP, S_AXI_RDATA};
    S_AXI_RREADY <= 0;
    @(posedge I_CORE_CLK);
  endtask
  // count direction is not fixed, so size is compared
  function automatic logic [31:0] mag(input logic [31:0] v);
    return v[31] ? -v : v;
  endfunction
  task pin;
    i_align_pin <= 1;
    repeat (8) @(posedge I_CORE_CLK);
    i_align_pin <= 0;
    wt;
  endtask
  // hang guard
  always @(posedge I_CORE_CLK) if (++cyc == 30000) begin
    fails++;
    conclude;
  end
  initial begin
    n = $urandom(32'hf318);
    repeat (8) @(posedge I_CORE_CLK);
    I_ARST_N <= 1;
    repeat (3) @(posedge I_CORE_CLK);
    ck("toggle", 1, o_link_toggle_out);
    rd(8'hFC);
    ck("unmapped", {2'b10, 32'h0}, r);
    wr(8'h2C, 3000);
    wr(8'h28, 16'h0008);
    rd(8'h48);
    ck("ramp", 3000, r);
    wr(8'h28, 16'h0018);
    wr(8'h2C, 9000);
    rd(8'h48);
    ck("frozen", 3000, r);
    wr(8'h24, 2);
    n = 2 * ($urandom % 16 + 4);
    repeat (2 * n) @(posedge I_CORE_CLK) stp <= !stp;
    wt;
    rd(8'h54);
    ck("pulses", n, mag(r[31:0]));
    rd(8'h50);
    ck("position", n / 2, mag(r[31:0]));
    n = $urandom % 1000 + 1;
    wr(8'h34, n);
    wr(8'h28, 16'h0800);
    ck("sync", 1, o_sync_done);
    rd(8'h50);
    ck("preset", n, r);
    wr(8'h28, 16'h2000);
    ck("syncclr", 0, o_sync_done);
    wr(8'h28, 16'h0000);
    i_running <= 0;
    pin;
    ck("idlepin", 0, o_sync_done);
    i_running <= 1;
    wr(8'h28, 16'h1000);
    pin;
    ck("blocked", 0, o_sync_done);
    wr(8'h28, 16'h0000);
    pin;
    ck("pinsync", 1, o_sync_done);
    wr(8'h00, 32'h0000_0200);
    rd(8'h44);
    ck("dsetbase", 4'hA, r[7:4]);
    ck("commflt", 1, o_comm_fault);
    w = $urandom & 16'h07EF | 16'h0100;
    wr(8'h28, w);
    ck("cmdbits", w, o_cmd_bits);
    ck("echo", !w[0], o_link_toggle_out);
    ck("commclr", !w[0], o_comm_fault);
    ck("speed", 9000, o_speed_ref);
    conclude;
  end
endmodule
`default_nettype wire
